/* dv/eight_bit_timer_counter_tb.sv */
// Self-checking bench for the eight-bit timer/counter.
// Assumes the package, header and design are compiled before it.
`timescale 1ns/100ps
`include "etc_consts.svh"
module eight_bit_timer_counter_tb
   import etc_pkg::*;
;
   // ====================================================================
   // Signals
   logic        ref_clk, srst, clk_en, sleep_mode;
   logic        watchdog_clear_instruction, ext_count_input;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, overflow_irq, watchdog_tick;
   logic [7:0]  timer_count_o, frz;
   logic        tick_seen;     // Set if the watchdog tap fires while gap is counting.
   int          fails, n_compared, n, c;
   int          cyc = 0;       // Cycle count for the hang limit.

   etc_timer i_etc_timer
   (
      .ref_clk, .srst, .clk_en, .ext_count_input, .sleep_mode,
      .watchdog_clear_instruction, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .overflow_irq,
      .watchdog_tick, .timer_count_o
   );
   etc_ext_source i_etc_ext_source
   (
      .count_pin(ext_count_input)
   );

   // ====================================================================
   // Clock and hang limit
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // The tests need a few thousand cycles; the ceiling leaves ample room.
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         complete_run();
      end
   end

   // ====================================================================
   // Helpers
   task automatic complete_run;
      $display("Counts: %0d compared, %0d failed", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic note(input string s);
      $display("Test %s finished", s);
   endtask

   // Pulse the watchdog clear for one cycle.
   task automatic wd_clear;
      watchdog_clear_instruction <= 1'b1;
      @(posedge ref_clk);
      watchdog_clear_instruction <= 1'b0;
   endtask

   // Write one byte; valids stay up until each channel is taken.
   // The answer readies stay high between transfers.
   task automatic wr(input logic [9:0] a, input logic [7:0] d,
                     input logic [1:0] er = `ETC_RESP_OKAY,
                     input logic [3:0] st = 4'hF);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wstrb   <= st;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
   endtask

   // Read one register and compare data and response.
   task automatic rd(input logic [9:0] a, input logic [7:0] e,
                     input logic [1:0] er = `ETC_RESP_OKAY);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, {24'h000000, e});
      chk(s_axi_rresp, er);
   endtask

   // Follow the count copy from the first cycle that shows v.
   task automatic hold_chk(input logic [7:0] v);
      int j;
      @(posedge ref_clk);
      while (timer_count_o !== v) @(posedge ref_clk);
      for (j = 1; j < 6; j++)
      begin
         @(posedge ref_clk);
         chk(timer_count_o, (j < 3) ? v : v + j - 2);
      end
   endtask

   // Cycles that the count copy stays at v once it appears.
   task automatic gap(input logic [7:0] v, output int k);
      while (timer_count_o !== v) @(posedge ref_clk);
      k = 0;
      while (timer_count_o === v)
      begin
         @(posedge ref_clk);
         k++;
         if (watchdog_tick === 1'b1)
            tick_seen = 1'b1;
      end
   endtask

   // One clean period: skip the first step, which may carry a hold.
   task automatic period(output int k);
      logic [7:0] p;
      @(posedge ref_clk);
      p = timer_count_o;
      while (timer_count_o === p) @(posedge ref_clk);
      gap(timer_count_o, k);
   endtask

   // ====================================================================
   // Test sequence
   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      sleep_mode = 1'b0;
      watchdog_clear_instruction = 1'b0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = '0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      fails = 0;
      n_compared = 0;
      tick_seen = 1'b0;
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      // Reset values, then an unmapped place both ways.
      rd(`ETC_ADDR_OPTION, 8'hFF);
      rd(`ETC_ADDR_PADIR, 8'h1F);
      rd(`ETC_ADDR_COUNT, 8'h00);
      rd(`ETC_ADDR_INTC, 8'h00);
      rd(10'h3F0, 8'h00, `ETC_RESP_SLVERR);
      wr(10'h3F0, 8'h55, `ETC_RESP_SLVERR);
      // A write without the low byte lane is answered but ignored.
      wr(`ETC_ADDR_OPTION, 8'h00, `ETC_RESP_OKAY, 4'hE);
      rd(`ETC_ADDR_OPTION, 8'hFF);
      note("reset");
      // Instruction-cycle counting, undivided, with the write hold.
      wr(`ETC_ADDR_OPTION, 8'h08);
      fork
         wr(`ETC_ADDR_COUNT, 8'h40);
         hold_chk(8'h40);
      join
      // With the clock enable low the running count must freeze.
      clk_en <= 1'b0;
      @(posedge ref_clk);
      frz = timer_count_o;
      repeat (20) @(posedge ref_clk);
      chk(timer_count_o, frz);
      clk_en <= 1'b1;
      note("timer");
      // Rollover flag, masking, sticky flag and sleep freeze.
      wr(`ETC_ADDR_COUNT, 8'hFD);
      repeat (20) @(posedge ref_clk);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge ref_clk);
      frz = timer_count_o;
      repeat (50) @(posedge ref_clk);
      chk(timer_count_o, frz);
      rd(`ETC_ADDR_COUNT, frz);
      rd(`ETC_ADDR_INTC, 8'h04);
      chk(overflow_irq, 1'b0);
      wr(`ETC_ADDR_INTC, 8'h24);
      repeat (3) @(posedge ref_clk);
      chk(overflow_irq, 1'b1);
      wr(`ETC_ADDR_INTC, 8'h20);
      repeat (3) @(posedge ref_clk);
      chk(overflow_irq, 1'b0);
      rd(`ETC_ADDR_INTC, 8'h20);
      sleep_mode <= 1'b0;
      wr(`ETC_ADDR_INTC, 8'h00);
      note("overflow");
      wd_clear();
      // Every ratio code with the prescaler on the timer.
      for (c = 0; c < 8; c++)
      begin
         wr(`ETC_ADDR_OPTION, {5'b00000, c[2:0]});
         wr(`ETC_ADDR_COUNT, 8'h00);
         period(n);
         chk(n, 32'd1 << (c + 1));
      end
      chk(tick_seen, 1'b0);
      // A count write mid-way must restart the divide by 256.
      repeat (100) @(posedge ref_clk);
      fork
         wr(`ETC_ADDR_COUNT, 8'h80);
         gap(8'h80, n);
      join
      chk(n >= 256 && n <= 259, 1'b1);
      note("prescaler");
      // Watchdog clear restarts the shared prescaler.
      wd_clear();
      wr(`ETC_ADDR_COUNT, 8'h00);
      wr(`ETC_ADDR_OPTION, 8'h0F);
      repeat (200) @(posedge ref_clk);
      wd_clear();
      n = 0;
      while (watchdog_tick !== 1'b1)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(n >= 100 && n <= 260, 1'b1);
      note("watchdog");
      // Pin counting on each edge choice, then divided by two.
      wr(`ETC_ADDR_OPTION, 8'h28);
      wr(`ETC_ADDR_COUNT, 8'h00);
      i_etc_ext_source.set_level(1'b1);
      repeat (10) @(posedge ref_clk);
      chk(timer_count_o, 8'h01);
      i_etc_ext_source.set_level(1'b0);
      repeat (10) @(posedge ref_clk);
      chk(timer_count_o, 8'h01);
      i_etc_ext_source.pulses(5);
      repeat (10) @(posedge ref_clk);
      rd(`ETC_ADDR_COUNT, 8'h06);
      wr(`ETC_ADDR_OPTION, 8'h38);
      wr(`ETC_ADDR_COUNT, 8'h00);
      i_etc_ext_source.set_level(1'b1);
      repeat (10) @(posedge ref_clk);
      chk(timer_count_o, 8'h00);
      i_etc_ext_source.set_level(1'b0);
      repeat (10) @(posedge ref_clk);
      chk(timer_count_o, 8'h01);
      wd_clear();
      wr(`ETC_ADDR_OPTION, 8'h20);
      wr(`ETC_ADDR_COUNT, 8'h00);
      i_etc_ext_source.pulses(6);
      repeat (10) @(posedge ref_clk);
      rd(`ETC_ADDR_COUNT, 8'h03);
      note("counter");
      complete_run();
   end
endmodule // eight_bit_timer_counter_tb

/* dv/etc_ext_source.sv */
// Model of the external clock source that drives the count input pin.
// Assumes the bench calls its tasks; the pin idles low between bursts.
`timescale 1ns/100ps
module etc_ext_source
#(
   parameter int HALF_NS = 48  // Each level lasts six core periods.
)
(
   output logic count_pin
);
   // ====================================================================
   // Pin driving
   // The source stands still low outside bursts, like a gated clock.
   initial count_pin = 1'b0;

   // A single static level, used to show one edge at a time.
   task automatic set_level(input logic v);
      count_pin <= v;
   endtask

   // A burst of full pulses; wide levels keep the sampling margin.
   task automatic pulses(input int n);
      repeat (n)
      begin
         count_pin <= 1'b1;
         #(HALF_NS);
         count_pin <= 1'b0;
         #(HALF_NS);
      end
   endtask
endmodule // etc_ext_source

/* logic/etc_consts.svh */
// Constants of the eight-bit timer/counter block.
// Assumes it is included by the bench and the module by its bare name.
// Behaviour
// - Source select zero counts instruction cycles.
// - Count write holds counting for two cycles.
// - Source select one counts external input edges.
// - Edge select zero rising, one falling.
// - Assign bit routes prescaler to timer or watchdog.
// - Ratio bits select 1:2 up to 1:256.
// - Prescaler count never visible to software.
// - Rollover from maximum to zero sets flag.
// - Interrupt request only while enable bit set.
// - Flag stays set until software clears it.
// - Sleep stops the timer completely.
// - Count source synchronised by two samples.
// - Count follows input change within bounded delay.
// - External input synchronised before division.
// - One shared eight-bit prescaler only.
// - Count write clears prescaler when assigned timer.
// - Watchdog clear clears prescaler when assigned watchdog.
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH
// ========================================================
// Register byte addresses (index times four).
`define ETC_IDX_COUNT   8'h01
`define ETC_IDX_INTC    8'h0B
`define ETC_IDX_OPTION  8'h81
`define ETC_IDX_PADIR   8'h85
`define ETC_ADDR_COUNT  10'h004
`define ETC_ADDR_INTC   10'h02C
`define ETC_ADDR_OPTION 10'h204
`define ETC_ADDR_PADIR  10'h214
// ========================================================
// Field positions and reset values.
`define ETC_BIT_CS      5
`define ETC_BIT_SE      4
`define ETC_BIT_PASSIGN 3
`define ETC_BIT_IE      5
`define ETC_BIT_IF      2
`define ETC_RST_OPTION  8'hFF
`define ETC_RST_PADIR   5'h1F
`define ETC_RST_BYTE    8'h00
`define ETC_MAX_COUNT   8'hFF
`define ETC_HOLD_CYC    2'h2
`define ETC_RESP_OKAY   2'h0
`define ETC_RESP_SLVERR 2'h2
`endif

/* logic/etc_pkg.sv */
// Types shared by the timer/counter block.
// Assumes the constants header is available on the include path.
package etc_pkg;
   // AXI4-Lite write data beat carried as one bundle.
   typedef struct packed {
      logic [31:0] wdata;
      logic [3:0]  wstrb;
   } etc_wbeat_t;
   // Answer phase of the slave.
   typedef enum logic [1:0] {
      ETC_IDLE = 2'b00,
      ETC_RESP = 2'b01
   } etc_bst_t;
endpackage

/* logic/etc_timer.sv */
// Eight-bit timer/counter with shared prescaler and AXI4-Lite registers.
// Assumes one clock ref_clk, sync reset srst, pin inputs asynchronous.
`timescale 1ns/100ps
`include "etc_consts.svh"
module etc_timer
   import etc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   input  wire logic        ext_count_input,
   input  wire logic        sleep_mode,
   input  wire logic        watchdog_clear_instruction,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             overflow_irq,
   output logic             watchdog_tick,
   output logic [7:0]       timer_count_o
);
   // ========================================================
   // Register state.
   logic [7:0] timer_count_r;   // Software visible count.
   logic [7:0] option_r;        // Source, edge, assign and ratio.
   logic       overflow_flag_r; // Sticky rollover flag.
   logic       overflow_irq_enable_r; // Interrupt mask bit.
   logic [5:0] intc_other_r;    // Remaining control bits, stored only.
   logic [4:0] padir_r;         // Port A direction, stored only.
   logic [7:0] presc_r;         // Shared prescaler, never readable.
   logic [1:0] hold_r;          // Cycles left of write hold.
   logic       ext_s1_r;        // First synchroniser stage.
   logic       ext_s2_r;        // Second synchroniser stage.
   logic       ext_s3_r;        // Previous synchronised level.

   // Bus handshake state.
   logic       aw_got_r;
   logic       w_got_r;
   logic [9:0] awaddr_r;
   etc_wbeat_t wbeat_r;
   etc_bst_t   bst_r;

   // ========================================================
   // Decode helpers.
   // Returns true when the byte enables cover the low byte.
   function automatic logic low_lane(input logic [3:0] strb);
      low_lane = strb[0];
   endfunction

   // Returns the prescaler bit that toggles at ratio 2^(code+1).
   function automatic logic ratio_tap(input logic [7:0] cnt,
                                      input logic [2:0] code);
      ratio_tap = cnt[code];
   endfunction

   // ========================================================
   // Write decode: both halves captured, then committed once.
   logic wr_fire;
   logic wr_count;
   logic wr_intc;
   logic wr_opt;
   logic wr_padir;
   logic wr_hit;
   assign wr_fire  = aw_got_r && w_got_r && (bst_r == ETC_IDLE);
   assign wr_hit   = wr_fire && low_lane(wbeat_r.wstrb);
   assign wr_count = wr_hit && (awaddr_r == `ETC_ADDR_COUNT);
   assign wr_intc  = wr_hit && (awaddr_r == `ETC_ADDR_INTC);
   assign wr_opt   = wr_hit && (awaddr_r == `ETC_ADDR_OPTION);
   assign wr_padir = wr_hit && (awaddr_r == `ETC_ADDR_PADIR);

   // ========================================================
   // Write channel capture; each half is taken when offered.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= 10'h000;
         wbeat_r       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else if (clk_en)
      begin
         // Ready is asserted for one cycle when the half is free.
         s_axi_awready <= !aw_got_r && s_axi_awvalid && !s_axi_awready;
         s_axi_wready  <= !w_got_r && s_axi_wvalid && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[9:2], 2'b00};
         end
         else if (wr_fire)
         begin
            aw_got_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_r <= 1'b1;
            wbeat_r <= '{wdata: s_axi_wdata, wstrb: s_axi_wstrb};
         end
         else if (wr_fire)
         begin
            w_got_r <= 1'b0;
         end
      end
   end

   // ========================================================
   // Write response; unmapped addresses answer with an error.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         bst_r        <= ETC_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ETC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         unique case (bst_r)
            ETC_IDLE:
            begin
               if (wr_fire)
               begin
                  bst_r        <= ETC_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= (awaddr_r == `ETC_ADDR_COUNT  ||
                                   awaddr_r == `ETC_ADDR_INTC   ||
                                   awaddr_r == `ETC_ADDR_OPTION ||
                                   awaddr_r == `ETC_ADDR_PADIR)
                                  ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
               end
            end
            ETC_RESP:
            begin
               if (s_axi_bready)
               begin
                  bst_r        <= ETC_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default:
            begin
               bst_r <= ETC_IDLE;
            end
         endcase
      end
   end

   // ========================================================
   // Read channel; one cycle from address to data.
   // The prescaler has no address, so it cannot be read.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `ETC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ETC_RESP_OKAY;
            unique case ({s_axi_araddr[9:2], 2'b00})
               `ETC_ADDR_COUNT:  s_axi_rdata <= {24'h0, timer_count_r};
               `ETC_ADDR_INTC:   s_axi_rdata <= {24'h0, intc_other_r[5:4],
                                   overflow_irq_enable_r, intc_other_r[3:2],
                                   overflow_flag_r, intc_other_r[1:0]};
               `ETC_ADDR_OPTION: s_axi_rdata <= {24'h0, option_r};
               `ETC_ADDR_PADIR:  s_axi_rdata <= {27'h0, padir_r};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `ETC_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ========================================================
   // Configuration registers.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         option_r              <= `ETC_RST_OPTION;
         padir_r               <= `ETC_RST_PADIR;
         overflow_irq_enable_r <= 1'b0;
         intc_other_r          <= 6'h00;
      end
      else if (clk_en)
      begin
         if (wr_opt)
         begin
            option_r <= wbeat_r.wdata[7:0];
         end
         if (wr_padir)
         begin
            padir_r <= wbeat_r.wdata[4:0];
         end
         if (wr_intc)
         begin
            overflow_irq_enable_r <= wbeat_r.wdata[`ETC_BIT_IE];
            intc_other_r <= {wbeat_r.wdata[7:6], wbeat_r.wdata[4:3],
                             wbeat_r.wdata[1:0]};
         end
      end
   end

   // ========================================================
   // Pin synchroniser; the first stage feeds only the second.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end
      else if (clk_en)
      begin
         ext_s1_r <= ext_count_input;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // ========================================================
   // Event selection: instruction cycle or chosen pin edge.
   // A synchronous divider stands in for the ripple counter so that
   // no logic runs on the pin itself; the divided tap stays symmetric.
   logic ext_edge;
   logic src_evt;
   logic to_timer;
   logic presc_tick;
   logic tap_now;
   logic tap_next;
   assign to_timer = !option_r[`ETC_BIT_PASSIGN];
   assign ext_edge = option_r[`ETC_BIT_SE] ? (ext_s3_r && !ext_s2_r)
                                           : (!ext_s3_r && ext_s2_r);
   assign src_evt  = option_r[`ETC_BIT_CS] ? ext_edge : 1'b1;
   assign tap_now  = ratio_tap(presc_r, option_r[2:0]);
   assign tap_next = ratio_tap(presc_r + 8'h01, option_r[2:0]);
   // A tick is the falling edge of the selected divider bit.
   assign presc_tick = src_evt && tap_now && !tap_next;

   // ========================================================
   // Shared prescaler: timer source when assigned, else watchdog
   // instruction cycles; one counter for both users.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         presc_r       <= `ETC_RST_BYTE;
         watchdog_tick <= 1'b0;
      end
      else if (clk_en)
      begin
         watchdog_tick <= 1'b0;
         if (to_timer && wr_count)
         begin
            presc_r <= `ETC_RST_BYTE;
         end
         else if (!to_timer && watchdog_clear_instruction)
         begin
            presc_r <= `ETC_RST_BYTE;
         end
         else if (to_timer && !sleep_mode && src_evt)
         begin
            presc_r <= presc_r + 8'h01;
         end
         else if (!to_timer)
         begin
            presc_r  <= presc_r + 8'h01;
            watchdog_tick <= tap_now && !tap_next;
         end
      end
   end

   // ========================================================
   // Count register, hold after write, and sticky overflow flag.
   logic cnt_evt;
   logic rollover;
   assign cnt_evt  = to_timer ? presc_tick : src_evt;
   assign rollover = cnt_evt && !sleep_mode && (hold_r == 2'h0) &&
                     !wr_count && (timer_count_r == `ETC_MAX_COUNT);

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         timer_count_r <= `ETC_RST_BYTE;
         hold_r        <= 2'h0;
      end
      else if (clk_en)
      begin
         if (wr_count)
         begin
            timer_count_r <= wbeat_r.wdata[7:0];
            hold_r        <= `ETC_HOLD_CYC;
         end
         else if (hold_r != 2'h0)
         begin
            hold_r <= hold_r - 2'h1;
         end
         else if (cnt_evt && !sleep_mode)
         begin
            timer_count_r <= timer_count_r + 8'h01;
         end
      end
   end

   // Hardware set wins over a software clear in the same cycle.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         overflow_flag_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rollover)
         begin
            overflow_flag_r <= 1'b1;
         end
         else if (wr_intc)
         begin
            overflow_flag_r <= wbeat_r.wdata[`ETC_BIT_IF];
         end
      end
   end

   // Registered outputs.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         overflow_irq  <= 1'b0;
         timer_count_o <= `ETC_RST_BYTE;
      end
      else if (clk_en)
      begin
         overflow_irq  <= overflow_flag_r && overflow_irq_enable_r;
         timer_count_o <= timer_count_r;
      end
   end

   // ========================================================
   // Assertions.
   // A committed count write, then two enabled cycles with no new write.
   sequence s_write_count;
      clk_en && wr_count;
   endsequence
   sequence s_quiet2;
      (clk_en && !wr_count) [*2];
   endsequence

   // Both hold edges must leave the written value in place.
   property p_hold;
      @(posedge ref_clk) disable iff (srst)
      s_write_count ##1 s_quiet2 |=> $stable(timer_count_r) &&
         $past(timer_count_r) == $past(timer_count_r, 2);
   endproperty
   a_hold: assert property (p_hold)
      else $error("count moved during write hold");

   property p_timer_mode;
      @(posedge ref_clk) disable iff (srst)
      clk_en && !option_r[`ETC_BIT_CS] && option_r[`ETC_BIT_PASSIGN] &&
      hold_r == 2'h0 &&
      !wr_count && !sleep_mode |=> timer_count_r == $past(timer_count_r) + 8'h01;
   endproperty
   a_timer_mode: assert property (p_timer_mode)
      else $error("timer mode did not advance");

   property p_flag;
      @(posedge ref_clk) disable iff (srst)
      clk_en && rollover |=> overflow_flag_r && timer_count_r == 8'h00;
   endproperty
   a_flag: assert property (p_flag)
      else $error("rollover did not set flag");

   property p_sticky;
      @(posedge ref_clk) disable iff (srst)
      overflow_flag_r && !wr_intc |=> overflow_flag_r;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without clear");

   property p_mask;
      @(posedge ref_clk) disable iff (srst)
      clk_en && !overflow_irq_enable_r |=> !overflow_irq;
   endproperty
   a_mask: assert property (p_mask)
      else $error("masked interrupt raised");

   property p_sleep;
      @(posedge ref_clk) disable iff (srst)
      sleep_mode && !wr_count |=> $stable(timer_count_r);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("timer ran in sleep");

   property p_presc_clr;
      @(posedge ref_clk) disable iff (srst)
      clk_en && to_timer && wr_count |=> presc_r == 8'h00;
   endproperty
   a_presc_clr: assert property (p_presc_clr)
      else $error("count write kept prescaler");

   property p_watchdog_clr;
      @(posedge ref_clk) disable iff (srst)
      clk_en && !to_timer && watchdog_clear_instruction |=> presc_r == 8'h00;
   endproperty
   a_watchdog_clr: assert property (p_watchdog_clr)
      else $error("watchdog clear kept prescaler");

   property p_sync;
      @(posedge ref_clk) disable iff (srst)
      clk_en && option_r[`ETC_BIT_CS] && ext_edge |->
         $past(ext_count_input, 2) != $past(ext_count_input, 3) ||
         !$past(clk_en) || !$past(clk_en, 2) || !$past(clk_en, 3);
   endproperty
   a_sync: assert property (p_sync)
      else $error("edge not from synchronised pin");

endmodule // etc_timer
